// ### design/fosf_pkg.sv
// Package with pin, command and timing constants for the flash status controller.
package fosf_pkg;
    localparam int unsigned CLK_MHZ          = 10;
    localparam int unsigned ACCESS_NS        = 200;
    localparam int unsigned ACCESS_CYC       = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RECOVER_NS       = 100;
    localparam int unsigned RECOVER_CYC      = (RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W            = 8;
    localparam int unsigned ADDR_W           = 19;
    localparam int unsigned DATA_W           = 16;
    localparam int unsigned POLLING_BIT_POS  = 7;
    localparam int unsigned TOGGLE_ONE_POS   = 6;
    localparam int unsigned TIMEOUT_POS      = 5;
    localparam int unsigned WINDOW_POS       = 3;
    localparam int unsigned TOGGLE_TWO_POS   = 2;
    localparam logic [7:0]  CMD_RESET        = 8'hf0;
    localparam logic [1:0]  RES_DONE         = 2'h0;
    localparam logic [1:0]  RES_FAIL         = 2'h1;
    localparam logic [1:0]  RES_REFUSED      = 2'h2;

    typedef enum logic [2:0] {
        FOSF_IDLE    = 3'b000,
        FOSF_SETUP   = 3'b001,
        FOSF_STROBE  = 3'b011,
        FOSF_RECOVER = 3'b010,
        FOSF_DECIDE  = 3'b110
    } fosf_state_type;

    typedef enum logic [1:0] {
        FOSF_OP_WRITE = 2'h0,
        FOSF_OP_READ  = 2'h1,
        FOSF_OP_POLL  = 2'h2,
        FOSF_OP_CHECK = 2'h3
    } fosf_op_type;
endpackage : fosf_pkg

// ### design/fosf_bus_cycle.sv
// One asynchronous flash bus cycle (read or write) timed in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module fosf_bus_cycle (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        clk_en,
    input  wire logic                        start,
    input  wire logic                        is_write,
    input  wire logic [fosf_pkg::ADDR_W-1:0] addr,
    input  wire logic [fosf_pkg::DATA_W-1:0] wdata,
    input  wire logic                        byte_mode,
    output logic                             done,
    output logic [fosf_pkg::DATA_W-1:0]      rdata,
    output logic [fosf_pkg::ADDR_W-1:0]      flash_addr,
    output logic                             low_address_bit_o,
    output logic                             chip_enable_n,
    output logic                             output_enable_n,
    output logic                             write_enable_n,
    input  wire logic [fosf_pkg::DATA_W-1:0] dq_i,
    output logic [fosf_pkg::DATA_W-1:0]      dq_o,
    output logic [fosf_pkg::DATA_W-1:0]      dq_oe
);
    fosf_pkg::fosf_state_type   state_q;
    logic [fosf_pkg::CNT_W-1:0] cnt_q;
    logic                       wr_q;

    assign done = (state_q == fosf_pkg::FOSF_RECOVER) && (cnt_q == '0) && clk_en;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q           <= fosf_pkg::FOSF_IDLE;
            cnt_q             <= '0;
            wr_q              <= 1'b0;
            rdata             <= '0;
            flash_addr        <= '0;
            low_address_bit_o <= 1'b0;
            chip_enable_n     <= 1'b1;
            output_enable_n   <= 1'b1;
            write_enable_n    <= 1'b1;
            dq_o              <= '0;
            dq_oe             <= '0;
        end else if (clk_en) begin
            case (state_q)
                fosf_pkg::FOSF_IDLE: begin
                    if (start) begin
                        wr_q              <= is_write;
                        flash_addr        <= addr;
                        low_address_bit_o <= byte_mode & wdata[fosf_pkg::DATA_W-1];
                        // In byte mode the top data pin carries the lowest address bit.
                        dq_oe             <= {byte_mode, {(fosf_pkg::DATA_W-1){is_write}}};
                        if (is_write) begin
                            // Commands always sit on the low byte.
                            dq_o <= byte_mode ? {8'h00, wdata[7:0]} : wdata;
                        end
                        chip_enable_n   <= 1'b0;
                        cnt_q           <= fosf_pkg::CNT_W'(fosf_pkg::ACCESS_CYC);
                        state_q         <= fosf_pkg::FOSF_STROBE;
                    end
                end
                fosf_pkg::FOSF_STROBE: begin
                    write_enable_n  <= ~wr_q;
                    output_enable_n <= wr_q;
                    if (cnt_q == '0) begin
                        if (!wr_q) begin
                            rdata <= byte_mode ? {8'h00, dq_i[7:0]} : dq_i;
                        end
                        // Chip enable stays low one more cycle so the strobe edge is seen selected.
                        write_enable_n  <= 1'b1;
                        output_enable_n <= 1'b1;
                        cnt_q           <= fosf_pkg::CNT_W'(fosf_pkg::RECOVER_CYC);
                        state_q         <= fosf_pkg::FOSF_RECOVER;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                fosf_pkg::FOSF_RECOVER: begin
                    // Both strobes stay high here, so address may change.
                    dq_oe         <= '0;
                    chip_enable_n <= 1'b1;
                    if (cnt_q == '0) begin
                        state_q <= fosf_pkg::FOSF_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: state_q <= fosf_pkg::FOSF_IDLE;
            endcase
        end
    end
endmodule : fosf_bus_cycle
`default_nettype wire

// ### design/fosf_host.sv
// Host controller that writes flash commands and tracks operation status bits.
`timescale 1ns/1ps
`default_nettype none
module fosf_host (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        clk_en,
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire logic [1:0]                  req_op,
    input  wire logic                        req_is_program,
    input  wire logic [fosf_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [fosf_pkg::DATA_W-1:0] req_data,
    input  wire logic                        byte_mode,
    output logic                             resp_valid,
    output logic [1:0]                       resp_code,
    output logic [fosf_pkg::DATA_W-1:0]      resp_data,
    output logic                             window_open,
    output logic [fosf_pkg::ADDR_W-1:0]      flash_addr,
    output logic                             low_address_bit_o,
    output logic                             low_address_bit_oe,
    output logic                             chip_enable_n,
    output logic                             output_enable_n,
    output logic                             write_enable_n,
    output logic                             width_select_n,
    input  wire logic [fosf_pkg::DATA_W-1:0] dq_i,
    output logic [fosf_pkg::DATA_W-1:0]      dq_o,
    output logic [fosf_pkg::DATA_W-1:0]      dq_oe,
    input  wire logic                        ready_busy_n
);
    typedef enum logic [2:0] {
        FOSF_H_IDLE  = 3'b000,
        FOSF_H_CYC   = 3'b001,
        FOSF_H_READ2 = 3'b011,
        FOSF_H_EVAL  = 3'b010,
        FOSF_H_RESET = 3'b110,
        FOSF_H_WIN2  = 3'b111
    } fosf_hstate_type;

    fosf_hstate_type            hstate_q;
    fosf_pkg::fosf_op_type      op_q;
    logic [fosf_pkg::ADDR_W-1:0] addr_q;
    logic [fosf_pkg::DATA_W-1:0] data_q;
    logic [7:0]                 first_q;
    logic                       rechecked_q;
    logic                       win_before_q;
    logic                       cyc_start;
    logic                       cyc_write;
    logic [fosf_pkg::DATA_W-1:0] cyc_wdata;
    logic                       cyc_done;
    logic [fosf_pkg::DATA_W-1:0] cyc_rdata;
    logic [fosf_pkg::DATA_W-1:0] dq_oe_raw;

    function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
        toggled = a[fosf_pkg::TOGGLE_ONE_POS] ^ b[fosf_pkg::TOGGLE_ONE_POS];
    endfunction : toggled

    assign req_ready          = (hstate_q == FOSF_H_IDLE);
    assign width_select_n     = ~byte_mode;
    assign low_address_bit_oe = dq_oe_raw[fosf_pkg::DATA_W-1] & byte_mode;
    assign dq_oe              = byte_mode ? {1'b0, 7'h00, dq_oe_raw[7:0]} : dq_oe_raw;
    assign cyc_start          = (hstate_q == FOSF_H_CYC) || (hstate_q == FOSF_H_READ2)
                             || (hstate_q == FOSF_H_RESET) || (hstate_q == FOSF_H_WIN2);
    assign cyc_write          = (hstate_q == FOSF_H_RESET)
                             || ((hstate_q == FOSF_H_CYC) && (op_q == fosf_pkg::FOSF_OP_WRITE));
    assign cyc_wdata          = (hstate_q == FOSF_H_RESET)
                             ? {8'h00, fosf_pkg::CMD_RESET} : data_q;

    fosf_bus_cycle u_cycle (
        .clk               (clk),
        .reset_n           (reset_n),
        .clk_en            (clk_en),
        .start             (cyc_start),
        .is_write          (cyc_write),
        .addr              (addr_q),
        .wdata             (cyc_wdata),
        .byte_mode         (byte_mode),
        .done              (cyc_done),
        .rdata             (cyc_rdata),
        .flash_addr        (flash_addr),
        .low_address_bit_o (low_address_bit_o),
        .chip_enable_n     (chip_enable_n),
        .output_enable_n   (output_enable_n),
        .write_enable_n    (write_enable_n),
        .dq_i              (dq_i),
        .dq_o              (dq_o),
        .dq_oe             (dq_oe_raw)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hstate_q     <= FOSF_H_IDLE;
            op_q         <= fosf_pkg::FOSF_OP_WRITE;
            addr_q       <= '0;
            data_q       <= '0;
            first_q      <= '0;
            rechecked_q  <= 1'b0;
            win_before_q <= 1'b0;
            resp_valid   <= 1'b0;
            resp_code    <= fosf_pkg::RES_DONE;
            resp_data    <= '0;
            window_open  <= 1'b0;
        end else if (clk_en) begin
            resp_valid <= 1'b0;
            case (hstate_q)
                FOSF_H_IDLE: begin
                    if (req_valid) begin
                        op_q        <= fosf_pkg::fosf_op_type'(req_op);
                        addr_q      <= req_addr;
                        data_q      <= req_data;
                        // A new poll always begins from the first read.
                        rechecked_q <= 1'b0;
                        hstate_q    <= FOSF_H_CYC;
                        if (fosf_pkg::fosf_op_type'(req_op) == fosf_pkg::FOSF_OP_WRITE
                            && req_is_program && !ready_busy_n) begin
                            // Busy device would drop it anyway.
                            resp_code  <= fosf_pkg::RES_REFUSED;
                            resp_valid <= 1'b1;
                            hstate_q   <= FOSF_H_IDLE;
                        end
                    end
                end
                FOSF_H_CYC: begin
                    if (cyc_done) begin
                        first_q   <= cyc_rdata[7:0];
                        resp_data <= cyc_rdata;
                        window_open <= ~cyc_rdata[fosf_pkg::WINDOW_POS];
                        win_before_q <= cyc_rdata[fosf_pkg::WINDOW_POS];
                        case (op_q)
                            fosf_pkg::FOSF_OP_POLL:  hstate_q <= FOSF_H_READ2;
                            fosf_pkg::FOSF_OP_CHECK: hstate_q <= FOSF_H_WIN2;
                            default: begin
                                resp_code  <= fosf_pkg::RES_DONE;
                                resp_valid <= 1'b1;
                                hstate_q   <= FOSF_H_IDLE;
                            end
                        endcase
                    end
                end
                FOSF_H_WIN2: begin
                    if (cyc_done) begin
                        resp_data   <= cyc_rdata;
                        window_open <= ~cyc_rdata[fosf_pkg::WINDOW_POS];
                        // Flag set on the second look: the erase may not have been taken.
                        resp_code   <= (cyc_rdata[fosf_pkg::WINDOW_POS] && !win_before_q)
                                     ? fosf_pkg::RES_REFUSED : fosf_pkg::RES_DONE;
                        resp_valid  <= 1'b1;
                        hstate_q    <= FOSF_H_IDLE;
                    end
                end
                FOSF_H_READ2: begin
                    if (cyc_done) begin
                        resp_data <= cyc_rdata;
                        if (!toggled(first_q, cyc_rdata[7:0])) begin
                            resp_code  <= fosf_pkg::RES_DONE;
                            resp_valid <= 1'b1;
                            hstate_q   <= FOSF_H_IDLE;
                        end else if (cyc_rdata[fosf_pkg::TIMEOUT_POS] && !rechecked_q) begin
                            first_q     <= cyc_rdata[7:0];
                            rechecked_q <= 1'b1;
                        end else if (rechecked_q) begin
                            hstate_q <= FOSF_H_RESET;
                        end else begin
                            first_q <= cyc_rdata[7:0];
                        end
                    end
                end
                FOSF_H_RESET: begin
                    if (cyc_done) begin
                        resp_code  <= fosf_pkg::RES_FAIL;
                        resp_valid <= 1'b1;
                        hstate_q   <= FOSF_H_IDLE;
                    end
                end
                default: hstate_q <= FOSF_H_IDLE;
            endcase
        end
    end
endmodule : fosf_host
`default_nettype wire

// ### verif/fosf_host_chk.sv
// Checker of the controller pins against the flash bus rules.
`timescale 1ns/1ps
`default_nettype none
module fosf_host_chk (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic [1:0]  req_op,
    input wire logic        req_is_program,
    input wire logic        byte_mode,
    input wire logic        resp_valid,
    input wire logic [1:0]  resp_code,
    input wire logic [18:0] flash_addr,
    input wire logic        low_address_bit_oe,
    input wire logic        chip_enable_n,
    input wire logic        output_enable_n,
    input wire logic        write_enable_n,
    input wire logic        width_select_n,
    input wire logic [15:0] dq_o,
    input wire logic [15:0] dq_oe,
    input wire logic        ready_busy_n
);
    logic [7:0] last_cmd_q;
    wire        take_prog = clk_en && req_valid && req_ready && req_op == 2'h0 && req_is_program;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last_cmd_q <= 8'h00;
        end else if (!write_enable_n) begin
            last_cmd_q <= dq_o[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_width_pins: assert property (width_select_n == !byte_mode && low_address_bit_oe == (byte_mode && !chip_enable_n))
        else $error("width pins disagree with byte mode");
    a_byte_upper: assert property (byte_mode |-> dq_oe[15:8] == 8'h00)
        else $error("upper data pins driven in byte mode");
    a_read_float: assert property (!output_enable_n |-> dq_oe == 16'h0000)
        else $error("data pins driven during a read");
    a_cmd_low_byte: assert property (!write_enable_n |-> dq_oe[7:0] == 8'hff)
        else $error("low byte not driven during a write");
    a_addr_stable: assert property (!chip_enable_n && !$past(chip_enable_n) |-> $stable(flash_addr))
        else $error("address moved while chip enable low");
    a_refuse_code: assert property (take_prog && !ready_busy_n && !$past(ready_busy_n) && !$past(ready_busy_n, 2) |=> resp_valid && resp_code == fosf_pkg::RES_REFUSED)
        else $error("busy program request not refused");
    a_refuse_quiet: assert property (take_prog && !ready_busy_n && !$past(ready_busy_n) && !$past(ready_busy_n, 2) |=> chip_enable_n [*2])
        else $error("refused request started a bus cycle");
    a_fail_reset: assert property (resp_valid && resp_code == fosf_pkg::RES_FAIL |-> last_cmd_q == fosf_pkg::CMD_RESET)
        else $error("failure reported without reset command");
    a_strobe_excl: assert property (!(output_enable_n == 1'b0 && write_enable_n == 1'b0))
        else $error("read and write strobes low together");
    c_refused: cover property (take_prog && !ready_busy_n);
    c_failed: cover property (resp_valid && resp_code == fosf_pkg::RES_FAIL);
    c_byte_read: cover property (byte_mode && !output_enable_n);
endmodule : fosf_host_chk
`default_nettype wire

// ### verif/fosf_flash_model.sv
// Behavioural flash device answering the controller's bus cycles.
`timescale 1ns/1ps
`default_nettype none
module fosf_flash_model (
    input wire logic        reset_n,
    input wire logic        chip_enable_n,
    input wire logic        output_enable_n,
    input wire logic        write_enable_n,
    input wire logic        width_select_n,
    input wire logic [18:0] flash_addr,
    input wire logic        low_address_bit,
    input wire logic [15:0] host_dq,
    input wire logic        stuck,
    input wire logic [7:0]  busy_reads,
    input wire logic [7:0]  window_reads,
    output logic     [15:0] dev_dq,
    output logic            busy_pull
);
    logic [2:0]  wr_cnt;
    logic [7:0]  reads;
    logic [7:0]  last_byte;
    logic        busy, failed, erase, tog1, tog2;
    logic [15:0] last_q;
    logic [15:0] val;
    logic [7:0]  stat;
    wire         drive = !chip_enable_n && !output_enable_n;
    assign stat = {~erase & ~last_byte[7], tog1, failed, 1'b0, erase & (reads > window_reads),
                   erase ? tog2 : 1'b1, 2'b00};
    assign val = busy ? {8'h00, stat} : {flash_addr[14:0], ~width_select_n & low_address_bit} ^ 16'h5a3c;
    // Undriven pins show the inverse of the last value so a stale read cannot match.
    assign dev_dq[7:0] = drive ? val[7:0] : ~last_q[7:0];
    assign dev_dq[15:8] = (drive && width_select_n) ? val[15:8] : ~last_q[15:8];
    assign busy_pull = busy || !reset_n;
    always @(posedge output_enable_n) last_q <= val;
    // Read strobes fall with write enable high; write strobes rise with output enable high.
    always @(posedge write_enable_n or negedge output_enable_n or negedge reset_n) begin
        if (!reset_n) begin
            wr_cnt <= 3'h0;
            {busy, failed, erase, tog1, tog2} <= 5'h00;
            {reads, last_byte} <= 16'h0000;
        end else if (drive && busy) begin
            tog1 <= ~tog1;
            tog2 <= erase ? ~tog2 : tog2;
            reads <= reads + 8'h01;
            failed <= stuck && reads >= 8'h02;
            busy <= stuck || reads + 8'h01 < busy_reads;
        end else if (!chip_enable_n && output_enable_n) begin
            if (host_dq[7:0] == 8'hf0 && (failed || !busy)) begin
                {busy, failed} <= 2'h0;
                wr_cnt <= 3'h0;
            end else if (!busy) begin
                wr_cnt <= wr_cnt + 3'h1;
                if (wr_cnt == 3'h2) erase <= host_dq[7:0] == 8'h80;
                if ((wr_cnt == 3'h3 && !erase) || wr_cnt == 3'h5) begin
                    busy <= 1'b1;
                    wr_cnt <= 3'h0;
                    reads <= 8'h00;
                    last_byte <= host_dq[7:0];
                end
            end
        end
    end
endmodule : fosf_flash_model
`default_nettype wire

// ### verif/fosf_host_tb.sv
// Self-checking bench for the flash status controller.
`timescale 1ns/1ps
`default_nettype none
module fosf_host_tb;
    logic        clk, reset_n, req_valid, req_ready, req_is_program, byte_mode, bm, stuck;
    logic        resp_valid, window_open, lab_o, lab_oe, ce_n, oe_n, we_n, ws_n, busy_pull;
    logic [1:0]  req_op, resp_code;
    logic [18:0] req_addr, flash_addr, a;
    logic [15:0] req_data, resp_data, dq_i, dq_o, dq_oe, dev_dq, d;
    logic [7:0]  busy_reads, window_reads;
    wire         ready_busy_n = ~busy_pull;
    int          num_errors, checks_done, i;
    assign dq_i[14:0] = (dq_oe[14:0] & dq_o[14:0]) | (~dq_oe[14:0] & dev_dq[14:0]);
    assign dq_i[15] = lab_oe ? lab_o : (dq_oe[15] ? dq_o[15] : dev_dq[15]);
    fosf_host u_fosf_host (.clk, .reset_n, .clk_en(1'b1), .req_valid, .req_ready, .req_op,
        .req_is_program, .req_addr, .req_data, .byte_mode, .resp_valid, .resp_code, .resp_data,
        .window_open, .flash_addr, .low_address_bit_o(lab_o), .low_address_bit_oe(lab_oe),
        .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(we_n),
        .width_select_n(ws_n), .dq_i, .dq_o, .dq_oe, .ready_busy_n);
    fosf_flash_model u_fosf_flash_model (.reset_n, .chip_enable_n(ce_n), .output_enable_n(oe_n),
        .write_enable_n(we_n), .width_select_n(ws_n), .flash_addr, .low_address_bit(lab_o),
        .host_dq(dq_o), .stuck, .busy_reads, .window_reads, .dev_dq, .busy_pull);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic tally(input logic ok, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (!ok) begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : tally
    task automatic check_code(input logic [1:0] got, input logic [1:0] exp);
        tally(got === exp, {14'h0, got}, {14'h0, exp});
    endtask : check_code
    task automatic check_data(input logic [15:0] got, input logic [15:0] exp);
        tally(got === exp, got, exp);
    endtask : check_data
    task automatic check_pin(input logic got, input logic exp);
        tally(got === exp, {15'h0, got}, {15'h0, exp});
    endtask : check_pin
    function automatic logic [15:0] expect_read(input logic [18:0] ad, input logic lb, input logic m);
        logic [15:0] p;
        p = {ad[14:0], m & lb} ^ 16'h5a3c;
        return m ? {8'h00, p[7:0]} : p;
    endfunction : expect_read
    task automatic req(input logic [1:0] op, input logic prog, input logic [18:0] ad, input logic [15:0] dt);
        int n;
        @(posedge clk);
        {req_valid, req_op, req_is_program, req_addr, req_data, byte_mode} <= {1'b1, op, prog, ad, dt, bm};
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 5000) begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, 1'b0, 1'b1);
        end
    endtask : req
    task automatic flash_cmd(input logic er);
        logic [7:0] sq [6];
        sq = '{8'haa, 8'h55, er ? 8'h80 : 8'ha0, er ? 8'haa : d[7:0], 8'h55, 8'h30};
        for (int k = 0; k < (er ? 6 : 4); k++) begin
            req(2'h0, k == (er ? 5 : 3), 19'(k), {8'h00, sq[k]});
            check_code(resp_code, fosf_pkg::RES_DONE);
        end
        check_pin(ready_busy_n, 1'b0);
    endtask : flash_cmd
    task automatic poll_expect(input logic [1:0] op, input logic [1:0] code);
        req(op, 1'b0, 19'h00010, 16'h0000);
        check_code(resp_code, code);
    endtask : poll_expect
    task automatic final_report;
        $display("checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        {reset_n, req_valid, req_op, req_is_program, byte_mode, bm, stuck} = 8'h00;
        {req_addr, req_data} = 35'h0;
        {busy_reads, window_reads} = {8'h05, 8'h14};
        void'($urandom(20252));
        repeat (10) @(posedge clk);
        check_pin(ready_busy_n, 1'b0);
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        for (i = 0; i < 16; i++) begin
            {a, d, bm} = {19'($urandom), 16'($urandom), i[0]};
            req(2'h1, 1'b0, a, d);
            check_data(bm ? {8'h00, resp_data[7:0]} : resp_data, expect_read(a, d[15], bm));
        end
        bm = 1'b0;
        flash_cmd(1'b0);
        req(2'h0, 1'b1, a, 16'h00aa);
        check_code(resp_code, fosf_pkg::RES_REFUSED);
        poll_expect(2'h2, fosf_pkg::RES_DONE);
        check_pin(ready_busy_n, 1'b1);
        busy_reads = 8'h28;
        flash_cmd(1'b1);
        poll_expect(2'h3, fosf_pkg::RES_DONE);
        check_pin(window_open, 1'b1);
        poll_expect(2'h2, fosf_pkg::RES_DONE);
        window_reads = 8'h01;
        flash_cmd(1'b1);
        poll_expect(2'h3, fosf_pkg::RES_REFUSED);
        check_pin(window_open, 1'b0);
        poll_expect(2'h2, fosf_pkg::RES_DONE);
        stuck = 1'b1;
        flash_cmd(1'b0);
        poll_expect(2'h2, fosf_pkg::RES_FAIL);
        check_pin(ready_busy_n, 1'b1);
        final_report;
    end
    initial begin
        #3000000;
        num_errors++;
        final_report;
    end
endmodule : fosf_host_tb
bind fosf_host fosf_host_chk u_fosf_host_chk (.clk, .reset_n, .clk_en, .req_valid, .req_ready,
    .req_op, .req_is_program, .byte_mode, .resp_valid, .resp_code, .flash_addr,
    .low_address_bit_oe, .chip_enable_n, .output_enable_n, .write_enable_n, .width_select_n,
    .dq_o, .dq_oe, .ready_busy_n);
`default_nettype wire
